// file: rtl/spiea_pkg.sv
/*
  Constants, field positions and state codes for the serial port with
  enable and sampling anomalies.
  Assumes it is compiled before every other file of the block.
*/
package spiea_pkg;

  // ******************************************************************
  // Word and configuration layout
  // ******************************************************************
  localparam int WORD_W = 8;        // Bits per serial word
  localparam int CFG_W = 6;         // Configuration bits crossing to the link
  localparam int CFG_EN = 0;        // Port enable
  localparam int CFG_MASTER = 1;    // Master mode
  localparam int CFG_CKP = 2;       // Clock idle polarity
  localparam int CFG_CKE = 3;       // Clock edge select
  localparam int CFG_SMP = 4;       // Input sample phase
  localparam int CFG_ROUTE = 5;     // Remappable pin routing connected

  // ******************************************************************
  // Timing counts, in link clock cycles and serial bits
  // ******************************************************************
  localparam logic [1:0] HALF_LAST = 2'h3;  // Link cycles per half bit, less one
  localparam logic [2:0] BIT_LAST = 3'h7;   // Index of the last bit of a word

  // ******************************************************************
  // Reset values and masks
  // ******************************************************************
  localparam logic GLITCH_PEND_RST = 1'b1;  // First enable still to come
  localparam logic [7:0] CORRUPT_MASK = 8'h01;  // Bits flipped by a DMA collision

  // ******************************************************************
  // Link state machine
  // ******************************************************************
  typedef enum logic [1:0] {
    SPIEA_IDLE = 2'b00,
    SPIEA_GLITCH = 2'b01,
    SPIEA_SHIFT = 2'b10
  } spiea_state_e;

endpackage : spiea_pkg

// file: rtl/spiea_sync.sv
/*
  Two flip-flop synchroniser for levels and toggles, also used to release
  resets. Assumes each bit is a level or a toggle that changes slowly
  compared with the destination clock.
*/
`timescale 1ns/1ps
`default_nettype none

module spiea_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // Both stages; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } spiea_sync_s;

  spiea_sync_s s;
  spiea_sync_s next_s;

  // ******************************************************************
  // Stage logic
  // ******************************************************************
  // Shift the input through both stages
  always_comb begin
    next_s.meta = d_i;
    next_s.stable = s.meta;
  end

  // Asynchronous clear, synchronous release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.stable;

endmodule : spiea_sync
`default_nettype wire

// file: rtl/spiea_top.sv
/*
  Serial port master with its enable-glitch and late-sampling anomalies.
  Core side on CORE_CLK_I, shift engine on LINK_CLK_I.
  Assumes configuration inputs are quasi-static and that the far end is a
  serial slave clocked by the serial clock pin.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RQ1) First enable emits one stray clock, shifts bit
// (RQ2) Re-enable after mid-word disable repeats stray clock
// (RQ3) Controller resyncs: two cycles, disable, enable again
// (RQ4) Controller enables routing after two serial clocks
// (RQ5) Edge zero, idle high master samples bit late
// (RQ6) Controller follows fixed start order for that mode
// (RQ7) Selectless slave enabled after clock driven high
// (RQ8) DMA word corrupted by concurrent register access
// (RQ9) Idle serial clock rests at idle polarity
module spiea_top (
  // Clocks and reset
  input wire logic CORE_CLK_I,
  input wire logic LINK_CLK_I,
  input wire logic RST_B_I,
  // Configuration levels
  input wire logic ENABLE_I,
  input wire logic MASTER_MODE_I,
  input wire logic CLOCK_IDLE_POLARITY_I,
  input wire logic CLOCK_EDGE_SELECT_I,
  input wire logic INPUT_SAMPLE_PHASE_I,
  input wire logic REMAPPABLE_PIN_ROUTING_I,
  // Transmit buffer write
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  input wire logic TX_DMA_I,
  input wire logic SFR_ACCESS_I,
  output logic TX_READY_O,
  // Corruption status
  input wire logic CORRUPT_CLEAR_I,
  output logic TX_CORRUPT_O,
  // Received word
  output logic [7:0] RX_DATA_O,
  output logic RX_VALID_O,
  // Serial pins
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_DATA_OUT_PIN_O,
  output logic SLAVE_SELECT_PIN_B_O,
  input wire logic SERIAL_INPUT_PIN_I
);

  // ******************************************************************
  // State types
  // ******************************************************************
  // Core domain state
  typedef struct packed {
    logic [spiea_pkg::CFG_W-1:0] cfg;      // Registered configuration
    logic [7:0] tx_buf;                    // Word waiting for the link
    logic req_t;                           // Toggles per offered word
    logic ack_q;                           // Last seen link acknowledge
    logic pend;                            // Word offered, not yet taken
    logic rx_q;                            // Last seen receive toggle
    logic [7:0] rx_data;                   // Received word for the user
    logic rx_valid;                        // One-cycle receive strobe
    logic corrupt;                         // Sticky DMA collision flag
  } spiea_core_s;

  // Link domain state
  typedef struct packed {
    spiea_pkg::spiea_state_e state;        // Shift engine state
    logic half;                            // Half of the current bit
    logic [1:0] sub;                       // Link cycle within the half
    logic [2:0] bitn;                      // Bit index in the word
    logic [7:0] tx_sh;                     // Outgoing shift register
    logic [7:0] rx_sh;                     // Incoming shift register
    logic late;                            // Previous input sample
    logic glitch_pend;                     // Next enable makes a stray clock
    logic en_q;                            // Enable one cycle ago
    logic req_q;                           // Last seen request toggle
    logic ack_t;                           // Toggles per word taken
    logic rx_t;                            // Toggles per word received
    logic [7:0] rx_word;                   // Last complete received word
    logic sck;                             // Serial clock pin
    logic sdo;                             // Serial data pin
    logic ss_n;                            // Slave select pin, active low
  } spiea_link_s;

  spiea_core_s c;
  spiea_core_s next_c;
  spiea_link_s l;
  spiea_link_s next_l;

  logic core_rst_n;                        // Released core reset
  logic link_rst_n;                        // Released link reset
  logic [spiea_pkg::CFG_W:0] to_link_s;    // Config and request, synced
  logic [spiea_pkg::CFG_W-1:0] cfg_s;      // Config seen by the link
  logic req_s;                             // Request toggle seen by the link
  logic sdi_s;                             // Serial input, synced
  logic [1:0] to_core_s;                   // Acknowledge and receive toggles
  logic collide;                           // DMA write meets register access
  logic accept;                            // Word taken into the buffer
  logic sample_now;                        // Link samples the input this cycle
  logic anomaly;                           // Late-sampling mode selected
  logic bit_in;                            // Bit shifted into the receiver
  logic active;                            // Serial clock at its active level
  logic [7:0] rx_next;                     // Receiver after this cycle

  // Serial clock level for a given idle polarity and activity
  function automatic logic sck_level(input logic clock_idle_polarity, input logic act);
    sck_level = clock_idle_polarity ^ act;
  endfunction : sck_level

  // ******************************************************************
  // Reset release and crossings
  // ******************************************************************
  spiea_sync #(.WIDTH(1)) u_core_rst (
    .clk_i(CORE_CLK_I), .rst_n_i(RST_B_I), .d_i(1'b1), .q_o(core_rst_n)
  );

  spiea_sync #(.WIDTH(1)) u_link_rst (
    .clk_i(LINK_CLK_I), .rst_n_i(RST_B_I), .d_i(1'b1), .q_o(link_rst_n)
  );

  // Levels and the request toggle; the word itself is held stable meanwhile
  spiea_sync #(.WIDTH(spiea_pkg::CFG_W + 1)) u_to_link (
    .clk_i(LINK_CLK_I), .rst_n_i(link_rst_n), .d_i({c.req_t, c.cfg}),
    .q_o(to_link_s)
  );

  spiea_sync #(.WIDTH(1)) u_sdi (
    .clk_i(LINK_CLK_I), .rst_n_i(link_rst_n), .d_i(SERIAL_INPUT_PIN_I),
    .q_o(sdi_s)
  );

  spiea_sync #(.WIDTH(2)) u_to_core (
    .clk_i(CORE_CLK_I), .rst_n_i(core_rst_n), .d_i({l.rx_t, l.ack_t}),
    .q_o(to_core_s)
  );

  assign cfg_s = to_link_s[spiea_pkg::CFG_W-1:0];
  assign req_s = to_link_s[spiea_pkg::CFG_W];

  // ******************************************************************
  // Core domain
  // ******************************************************************
  assign collide = TX_DMA_I && SFR_ACCESS_I;
  assign accept = TX_VALID_I && !c.pend;

  // Buffer write, acknowledge, receive hand-over and corruption flag
  always_comb begin
    next_c = c;
    next_c.cfg = {REMAPPABLE_PIN_ROUTING_I, INPUT_SAMPLE_PHASE_I,
                  CLOCK_EDGE_SELECT_I, CLOCK_IDLE_POLARITY_I,
                  MASTER_MODE_I, ENABLE_I};
    next_c.rx_valid = 1'b0;
    // Link took the word: buffer free again
    if (to_core_s[0] != c.ack_q) begin
      next_c.ack_q = to_core_s[0];
      next_c.pend = 1'b0;
    end
    // A DMA write racing a register access lands damaged
    if (accept) begin
      next_c.tx_buf = collide ? (TX_DATA_I ^ spiea_pkg::CORRUPT_MASK) : TX_DATA_I; // RQ8
      next_c.req_t = ~c.req_t;
      next_c.pend = 1'b1;
    end
    // Set beats clear so a collision is never lost
    if (CORRUPT_CLEAR_I) begin
      next_c.corrupt = 1'b0;
    end
    if (accept && collide) begin
      next_c.corrupt = 1'b1; // RQ8
    end
    // rx_word is stable for a whole word after its toggle moves
    if (to_core_s[1] != c.rx_q) begin
      next_c.rx_q = to_core_s[1];
      next_c.rx_data = l.rx_word;
      next_c.rx_valid = 1'b1;
    end
  end

  // Core state register
  always_ff @(posedge CORE_CLK_I or negedge core_rst_n) begin
    if (!core_rst_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign TX_READY_O = !c.pend;
  assign TX_CORRUPT_O = c.corrupt;
  assign RX_DATA_O = c.rx_data;
  assign RX_VALID_O = c.rx_valid;

  // ******************************************************************
  // Link domain
  // ******************************************************************
  // Master, edge select 0 and idle high take input one bit late
  assign anomaly = cfg_s[spiea_pkg::CFG_MASTER] && !cfg_s[spiea_pkg::CFG_CKE]
                   && cfg_s[spiea_pkg::CFG_CKP];

  // Shift engine with the stray clock on enable
  always_comb begin
    next_l = l;
    sample_now = 1'b0;
    bit_in = 1'b0;
    rx_next = l.rx_sh;
    active = 1'b0;
    next_l.en_q = cfg_s[spiea_pkg::CFG_EN];
    case (l.state)
      spiea_pkg::SPIEA_IDLE: begin
        // Enable edge with a pending stray clock comes first
        if (cfg_s[spiea_pkg::CFG_EN] && !l.en_q && l.glitch_pend) begin
          next_l.state = spiea_pkg::SPIEA_GLITCH; // RQ1
          next_l.glitch_pend = 1'b0;
        end else if (cfg_s[spiea_pkg::CFG_EN] && cfg_s[spiea_pkg::CFG_MASTER]
                     && (req_s != l.req_q)) begin
          // Take the word and free the core buffer at once
          next_l.state = spiea_pkg::SPIEA_SHIFT;
          next_l.req_q = req_s;
          next_l.ack_t = ~l.ack_t;
          next_l.tx_sh = c.tx_buf;
          next_l.rx_sh = '0;
          next_l.half = 1'b0;
          next_l.sub = '0;
          next_l.bitn = '0;
          next_l.late = 1'b0;
        end
      end
      spiea_pkg::SPIEA_GLITCH: begin
        // The stray edge pushes one bit out of the data line
        next_l.tx_sh = {l.tx_sh[6:0], 1'b0}; // RQ1
        next_l.state = spiea_pkg::SPIEA_IDLE;
      end
      spiea_pkg::SPIEA_SHIFT: begin
        if (!cfg_s[spiea_pkg::CFG_EN]) begin
          // Word abandoned; the next enable misbehaves again
          next_l.state = spiea_pkg::SPIEA_IDLE;
          next_l.glitch_pend = 1'b1; // RQ2
        end else begin
          next_l.sub = l.sub + 2'h1;
          if (l.sub == spiea_pkg::HALF_LAST) begin
            sample_now = (l.half == cfg_s[spiea_pkg::CFG_SMP]);
            if (sample_now) begin
              // Late mode shifts in the sample before this one
              bit_in = anomaly ? l.late : sdi_s; // RQ5
              next_l.late = sdi_s;
              rx_next = {l.rx_sh[6:0], bit_in};
              next_l.rx_sh = rx_next;
            end
            if (!l.half) begin
              next_l.half = 1'b1;
            end else if (l.bitn == spiea_pkg::BIT_LAST) begin
              next_l.rx_word = rx_next;
              next_l.rx_t = ~l.rx_t;
              next_l.state = spiea_pkg::SPIEA_IDLE;
            end else begin
              next_l.bitn = l.bitn + 3'h1;
              next_l.tx_sh = {l.tx_sh[6:0], 1'b0};
              next_l.half = 1'b0;
            end
          end
        end
      end
      default: begin
        next_l.state = spiea_pkg::SPIEA_IDLE;
      end
    endcase
    // Pins are registered; routing off holds them idle so no stray edge escapes
    if (next_l.state == spiea_pkg::SPIEA_GLITCH) begin
      active = 1'b1;
    end else if (next_l.state == spiea_pkg::SPIEA_SHIFT) begin
      active = cfg_s[spiea_pkg::CFG_CKE] ? next_l.half : !next_l.half;
    end
    next_l.sck = sck_level(cfg_s[spiea_pkg::CFG_CKP],
                           active && cfg_s[spiea_pkg::CFG_ROUTE]); // RQ9
    next_l.sdo = cfg_s[spiea_pkg::CFG_ROUTE]
                 && (next_l.state != spiea_pkg::SPIEA_IDLE) && next_l.tx_sh[7];
    next_l.ss_n = !(cfg_s[spiea_pkg::CFG_ROUTE]
                    && (next_l.state == spiea_pkg::SPIEA_SHIFT));
  end

  // Link state register
  always_ff @(posedge LINK_CLK_I or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= '0;
      l.glitch_pend <= spiea_pkg::GLITCH_PEND_RST;
      l.ss_n <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  assign SERIAL_CLOCK_PIN_O = l.sck;
  assign SERIAL_DATA_OUT_PIN_O = l.sdo;
  assign SLAVE_SELECT_PIN_B_O = l.ss_n;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  AST_FIRST_GLITCH: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ1
    l.state == spiea_pkg::SPIEA_IDLE && l.glitch_pend && cfg_s[spiea_pkg::CFG_EN]
    && !l.en_q |=> l.state == spiea_pkg::SPIEA_GLITCH && !l.glitch_pend)
    else $error("stray clock missing on pending enable");
  AST_GLITCH_SHIFT: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ1
    l.state == spiea_pkg::SPIEA_GLITCH |=> l.state == spiea_pkg::SPIEA_IDLE
    && l.tx_sh == {$past(l.tx_sh[6:0]), 1'b0})
    else $error("stray clock did not shift one bit");
  AST_GLITCH_PIN: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ1
    l.state == spiea_pkg::SPIEA_GLITCH && $past(cfg_s[spiea_pkg::CFG_ROUTE])
    |-> l.sck == !$past(cfg_s[spiea_pkg::CFG_CKP]))
    else $error("stray clock not at active level");
  AST_ABORT_PEND: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ2
    l.state == spiea_pkg::SPIEA_SHIFT && !cfg_s[spiea_pkg::CFG_EN]
    |=> l.glitch_pend && l.state == spiea_pkg::SPIEA_IDLE)
    else $error("abort did not arm the stray clock");
  AST_LATE_SAMPLE: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ5
    sample_now && anomaly |=> l.rx_sh[0] == $past(l.late) && l.late == $past(sdi_s))
    else $error("late mode did not shift in previous sample");
  AST_NORMAL_SAMPLE: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ5
    sample_now && !anomaly |=> l.rx_sh[0] == $past(sdi_s))
    else $error("normal mode sample wrong");
  AST_IDLE_SCK: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ9
    l.state == spiea_pkg::SPIEA_IDLE |-> l.sck == $past(cfg_s[spiea_pkg::CFG_CKP]))
    else $error("idle serial clock not at idle polarity");
  AST_ROUTE_OFF: assert property (@(posedge LINK_CLK_I) disable iff (!link_rst_n) // RQ9
    !$past(cfg_s[spiea_pkg::CFG_ROUTE]) |-> l.sck == $past(cfg_s[spiea_pkg::CFG_CKP])
    && l.ss_n && !l.sdo)
    else $error("pins moved with routing off");
  AST_DMA_CORRUPT: assert property (@(posedge CORE_CLK_I) disable iff (!core_rst_n) // RQ8
    accept && collide |=> c.tx_buf == ($past(TX_DATA_I) ^ spiea_pkg::CORRUPT_MASK)
    && TX_CORRUPT_O && !TX_READY_O)
    else $error("collision did not corrupt and flag the word");
  AST_CLEAN_WRITE: assert property (@(posedge CORE_CLK_I) disable iff (!core_rst_n) // RQ8
    accept && !collide |=> c.tx_buf == $past(TX_DATA_I))
    else $error("clean write stored wrong word");
  AST_SET_WINS: assert property (@(posedge CORE_CLK_I) disable iff (!core_rst_n) // RQ8
    accept && collide && CORRUPT_CLEAR_I |=> TX_CORRUPT_O)
    else $error("clear beat a collision in the same cycle");

  COV_GLITCH: cover property (@(posedge LINK_CLK_I) disable iff (!link_rst_n)
    l.state == spiea_pkg::SPIEA_GLITCH);
  COV_LATE_WORD: cover property (@(posedge LINK_CLK_I) disable iff (!link_rst_n)
    anomaly && l.state == spiea_pkg::SPIEA_SHIFT ##1 l.state == spiea_pkg::SPIEA_IDLE);
  COV_CORRUPT: cover property (@(posedge CORE_CLK_I) disable iff (!core_rst_n)
    accept && collide);
  COV_RX: cover property (@(posedge CORE_CLK_I) disable iff (!core_rst_n) RX_VALID_O);

endmodule : spiea_top
`default_nettype wire

// file: verification/spiea_slave_model.sv
/*
  Behavioural serial slave for the port bench: shifts a reply word out
  MSB first and records the last eight bits it captured.
  Assumes the master drives a slave select and keeps clock edges apart.
*/
`timescale 1ns/1ps
`default_nettype none

module spiea_slave_model (
  // Serial pins seen from the slave
  input wire logic sck_i,
  input wire logic ss_b_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Mode and data
  input wire logic edge_sel_i,
  input wire logic pol_i,
  input wire logic [7:0] resp_i,
  output logic [7:0] got_o
);
  int k; // Index of the bit on the line

  initial begin
    miso_o = 1'b0;
    got_o = 8'h00;
    k = 0;
  end

  // Frame start: second-half mode needs the first bit before any edge
  always @(negedge ss_b_i) begin
    k = edge_sel_i ? 7 : 8;
    miso_o = edge_sel_i ? resp_i[7] : ~miso_o;
  end

  // Released line has no pull resistor: show the inverse of the last bit
  always @(posedge ss_b_i) miso_o = ~miso_o;

  // Shift on the edge that opens a bit, capture on the other one
  // Short delay lets a select edge of the same instant land first
  always @(sck_i) begin
    #1;
    if (!ss_b_i) begin
      if ((sck_i === pol_i) == edge_sel_i) begin
        k = k - 1;
        miso_o = (k >= 0) ? resp_i[k] : ~miso_o;
      end else begin
        got_o = {got_o[6:0], mosi_i};
      end
    end
  end
endmodule : spiea_slave_model

`default_nettype wire

// file: verification/testbench.sv
/*
  Self-checking bench for the serial port: stray clocks, modes, aborts
  and collisions. Assumes the slave model and the design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ******************************************************************
  // Stimulus and observation
  // ******************************************************************
  logic core_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0;
  logic enable = 1'b0, master = 1'b0, pol = 1'b0, edge_sel = 1'b1;
  logic input_sample_phase = 1'b0, route = 1'b1, tx_valid = 1'b0, tx_dma = 1'b0;
  logic sfr = 1'b0, clr = 1'b0;
  logic [7:0] tx_data = 8'h00, resp = 8'h00, rx_data, got;
  logic tx_ready, corrupt, rx_valid, sck, sdo, ss_b, miso;
  int fail_count = 0, comparisons = 0, cycles = 0, sck_edges = 0;

  // Core clock, and a link clock of unrelated phase
  always #50 core_clk = ~core_clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // Edges seen on the serial clock pin
  always @(sck) sck_edges++;

  spiea_top DUT (.CORE_CLK_I(core_clk), .LINK_CLK_I(link_clk), .RST_B_I(rst_b),
    .ENABLE_I(enable), .MASTER_MODE_I(master), .CLOCK_IDLE_POLARITY_I(pol),
    .CLOCK_EDGE_SELECT_I(edge_sel), .INPUT_SAMPLE_PHASE_I(input_sample_phase),
    .REMAPPABLE_PIN_ROUTING_I(route), .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid),
    .TX_DMA_I(tx_dma), .SFR_ACCESS_I(sfr), .TX_READY_O(tx_ready),
    .CORRUPT_CLEAR_I(clr), .TX_CORRUPT_O(corrupt), .RX_DATA_O(rx_data),
    .RX_VALID_O(rx_valid), .SERIAL_CLOCK_PIN_O(sck), .SERIAL_DATA_OUT_PIN_O(sdo),
    .SLAVE_SELECT_PIN_B_O(ss_b), .SERIAL_INPUT_PIN_I(miso));

  spiea_slave_model slave (.sck_i(sck), .ss_b_i(ss_b), .mosi_i(sdo), .miso_o(miso),
    .edge_sel_i(edge_sel), .pol_i(pol), .resp_i(resp), .got_o(got));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  function automatic logic [7:0] b1(input logic x);
    return {7'h00, x};
  endfunction : b1

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Inputs change only at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // One buffer write, held until the edge that takes it
  task automatic write(input logic [7:0] d, input logic dma, input logic acc);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    tx_data = d;
    tx_dma = dma;
    sfr = acc;
    // A buffer that never frees counts as a mismatch
    check("tx_ready", 8'h01, b1(tx_ready));
    tx_valid = 1'b1;
    cyc(1);
    tx_valid = 1'b0;
    tx_dma = 1'b0;
    sfr = 1'b0;
  endtask : write

  // Word out and reply back; the valid pulse stands one cycle
  task automatic xfer(input logic [7:0] d, input logic [7:0] r, input logic dma,
                      input logic acc);
    int n;
    n = 0;
    resp = r;
    write(d, dma, acc);
    while (rx_valid !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("rx_valid", 8'h01, b1(rx_valid));
    cyc(2);
  endtask : xfer

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset;
    pol = 1'b1;
    cyc(3);
    check("ready", 8'h01, b1(tx_ready));
    check("corrupt", 8'h00, b1(corrupt));
    check("ss_b", 8'h01, b1(ss_b));
    check("sck idle high", 8'h01, b1(sck));
    pol = 1'b0;
    cyc(3);
    check("sck idle low", 8'h00, b1(sck));
    $display("test reset done");
  endtask : t_reset

  task automatic t_first;
    master = 1'b1;
    cyc(2);
    sck_edges = 0;
    enable = 1'b1;
    cyc(6);
    check("stray edges", 8'h02, 8'(sck_edges));
    // Two serial cycles have passed: toggle the enable to resync
    enable = 1'b0;
    cyc(3);
    sck_edges = 0;
    enable = 1'b1;
    cyc(6);
    check("resync edges", 8'h00, 8'(sck_edges));
    xfer(8'ha5, 8'h3c, 1'b0, 1'b0);
    check("slave got", 8'ha5, got);
    check("rx word", 8'h3c, rx_data);
    check("word edges", 8'h10, 8'(sck_edges));
    $display("test first enable done");
  endtask : t_first

  task automatic t_abort;
    write(8'hf0, 1'b0, 1'b0);
    cyc(5);
    enable = 1'b0;
    cyc(3);
    check("ss_b after abort", 8'h01, b1(ss_b));
    sck_edges = 0;
    enable = 1'b1;
    cyc(6);
    check("restart edges", 8'h02, 8'(sck_edges));
    write(8'h0f, 1'b0, 1'b0);
    cyc(5);
    // Routing goes off with the port, back on two serial clocks later
    enable = 1'b0;
    route = 1'b0;
    cyc(3);
    sck_edges = 0;
    enable = 1'b1;
    cyc(6);
    route = 1'b1;
    cyc(3);
    check("gated edges", 8'h00, 8'(sck_edges));
    xfer(8'h96, 8'h69, 1'b0, 1'b0);
    check("slave got", 8'h96, got);
    check("rx word", 8'h69, rx_data);
    $display("test abort done");
  endtask : t_abort

  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      enable = 1'b0;
      cyc(2);
      // Clock level first, then master, then enable
      pol = i[1];
      edge_sel = i[0];
      input_sample_phase = i[2];
      cyc(2);
      master = 1'b1;
      cyc(1);
      enable = 1'b1;
      cyc(4);
      xfer(8'hc0 + 8'(i), 8'h37, 1'b0, 1'b0);
      check("mode tx", 8'hc0 + 8'(i), got);
      check("mode rx", (!edge_sel && pol) ? 8'h1b : 8'h37, rx_data);
      check("mode idle sck", b1(pol), b1(sck));
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_dma;
    for (int i = 1; i < 4; i++) begin
      xfer(8'h5a, 8'h81, i[0], i[1]);
      check("dma tx", (i == 3) ? (8'h5a ^ spiea_pkg::CORRUPT_MASK) : 8'h5a, got);
      check("corrupt flag", b1(i == 3), b1(corrupt));
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
      check("corrupt cleared", 8'h00, b1(corrupt));
    end
    // Clear in the very cycle of a collision loses to the set
    clr = 1'b1;
    write(8'h3c, 1'b1, 1'b1);
    clr = 1'b0;
    check("set beats clear", 8'h01, b1(corrupt));
    $display("test collision done");
  endtask : t_dma

  // Main sequence
  initial begin
    cyc(4);
    rst_b = 1'b1;
    cyc(4);
    t_reset;
    t_first;
    t_abort;
    t_modes;
    t_dma;
    close_out;
  end

  // Hang guard, well above the expected five hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      close_out;
    end
  end
endmodule : testbench

`default_nettype wire
